/* pkg/pmgr_pkg.sv */
// Constants, register map and mode types for the idle/wake sequencer
// Behaviour
// R01 - Select 10 plus sleep enters primary idle
// R02 - Primary idle: CPU stopped, primary clocks peripherals
// R03 - Primary idle wake: primary clock, after ready delay
// R04 - Select 01 plus sleep enters secondary idle
// R05 - Secondary idle: primary off, flags swapped
// R06 - Secondary oscillator disabled: sleep ignored
// R07 - Secondary idle wake keeps secondary oscillator
// R08 - Select 00 enters internal idle, primary off
// R09 - Internal idle wake on RC; RC kept when needed
// R10 - Wake leaves idle bit and select unchanged
// R11 - Exit only by interrupt, reset or timeout
// R12 - Enabled interrupt flag starts exit
// R13 - Global enable chooses vector or in-line resume
// R14 - Every exit waits the ready delay
// R15 - Timeout wakes when halted, resets when running
// R16 - Sleep, clear or clock loss clears watchdog
// R17 - Reset exit forces internal RC
// R18 - Start-up timer skipped for primary idle, external
// R19 - Mismatch and reset-instruction flags cleared by event
// R20 - Timeout flag: 1 on clear/sleep, 0 on timeout
// R21 - Power-down flag: 1 on clear, 0 on sleep
// R22 - Power-on and brown-out flags cleared by event
// R23 - Idle bit chooses idle mode or full sleep
`default_nettype none
package pmgr_pkg;
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_RCAUSE = 12'h004;
    localparam logic [11:0] ADDR_STAT = 12'h008;
    localparam logic [11:0] ADDR_CMD = 12'h00C;
    localparam logic [11:0] ADDR_EVT = 12'h010;
    // Control register fields
    localparam int CTRL_IDLE = 0;
    localparam int CTRL_SEL = 1;
    localparam int CTRL_SECEN = 3;
    localparam int CTRL_WDTEN = 4;
    localparam int CTRL_FSCM = 5;
    localparam int CTRL_EXTCLK = 6;
    localparam int CTRL_REGEN = 7;
    // Reset cause register fields
    localparam int RC_PRIO = 7;
    localparam int RC_MISMATCH = 5;
    localparam int RC_RSTINSTR = 4;
    localparam int RC_TIMEOUT = 3;
    localparam int RC_PWRDN = 2;
    localparam int RC_POWERON = 1;
    localparam int RC_BROWNOUT = 0;
    localparam logic [7:0] RCAUSE_RST = 8'h3C;
    localparam logic [7:0] RCAUSE_WMASK = 8'hB3;
    // Command register bits (write one)
    localparam int CMD_SLEEP = 0;
    localparam int CMD_WATCHDOG_CLEAR_INSTR = 1;
    // Event register bits (write one, model of reset sources and clock loss)
    localparam int EV_POR = 0;
    localparam int EV_BOR = 1;
    localparam int EV_MISMATCH = 2;
    localparam int EV_RSTINSTR = 3;
    localparam int EV_CLKLOSS = 4;
    localparam logic [1:0] SEL_INT = 2'h0;
    localparam logic [1:0] SEL_SEC = 2'h1;
    localparam logic [1:0] SEL_PRI = 2'h2;
    localparam logic [1:0] SEL_RC = 2'h3;
    localparam int CLK_MHZ = 125;
    localparam int READY_DELAY_NS = 10000;
    localparam int READY_CYC = (READY_DELAY_NS * CLK_MHZ + 999) / 1000;
    localparam int OST_CYC = 1024;
    localparam int WDT_CYC = 4000;
    typedef enum logic [2:0] {
        MODE_RUN = 3'b000,
        MODE_SLEEP = 3'b001,
        MODE_PRIMARY_IDLE = 3'b010,
        MODE_SECONDARY_IDLE = 3'b011,
        MODE_INT_IDLE = 3'b100,
        MODE_OST = 3'b101,
        MODE_WAKE = 3'b110
    } mode_e;
    typedef enum logic [1:0] {
        SRC_PRI = 2'b00,
        SRC_SEC = 2'b01,
        SRC_RC = 2'b10
    } src_e;
endpackage
`default_nettype wire

/* rtl/pmgr_counter.sv */
// Down counter with load and done flag, used for delays and watchdog
`default_nettype none
module pmgr_counter #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic load,
    input wire logic [W-1:0] value,
    input wire logic run,
    output logic done
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic done;
    } cnt_s;
    cnt_s st_r;
    cnt_s st_nxt;
    always_comb begin
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        if (load) begin
            st_nxt.cnt = value;
        end else if (run && st_r.cnt != '0) begin
            st_nxt.cnt = st_r.cnt - 1'b1;
            if (st_r.cnt == {{(W-1){1'b0}}, 1'b1}) begin
                st_nxt.done = 1'b1;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign done = st_r.done;
endmodule
`default_nettype wire

/* rtl/pmgr_top.sv */
// Idle-mode entry, wake-up sequencing, watchdog and reset-cause flags
//
// Design decisions made here: the register offsets and the APB slave port.
`default_nettype none
module pmgr_top #(
    parameter int READY_CYCLES = pmgr_pkg::READY_CYC,
    parameter int OST_CYCLES = pmgr_pkg::OST_CYC,
    parameter int WDT_CYCLES = pmgr_pkg::WDT_CYC
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Interrupt wake inputs
    input wire logic [7:0] INT_FLAGS,
    input wire logic [7:0] INT_ENABLES,
    input wire logic GLOBAL_INT_EN,
    // Clock and core status
    output logic CPU_CLK_EN,
    output logic PERIPH_CLK_EN,
    output logic [1:0] CLK_SOURCE,
    output logic PRIMARY_OSC_ON,
    output logic SECONDARY_OSC_ON,
    output logic INTERNAL_RC_ON,
    output logic PRIMARY_CLOCK_RUNNING_FLAG,
    output logic SECONDARY_OSC_CLOCKING_FLAG,
    output logic CPU_RESUME,
    output logic BRANCH_TO_VECTOR,
    output logic WATCHDOG_RESET
);
    typedef struct packed {
        pmgr_pkg::mode_e mode;
        pmgr_pkg::src_e src;
        logic [7:0] ctrl;
        logic prio;
        logic mismatch_n;
        logic rstinstr_n;
        logic timeout_n;
        logic pwrdn_n;
        logic poweron_n;
        logic brownout_n;
        logic wake_irq;
        logic pri_on;
        logic resume;
        logic branch;
        logic wdt_rst;
        logic [31:0] rdata;
    } state_s;

    state_s st_r;
    state_s st_nxt;
    logic wr_en;
    logic rd_en;
    logic known;
    logic sleep_cmd;
    logic watchdog_clear_instr_cmd;
    logic [4:0] ev;
    logic irq_wake;
    logic wdt_done;
    logic ready_done;
    logic ost_done;
    logic ready_load;
    logic ost_load;
    logic wdt_load;
    logic halted;

    assign wr_en = PSEL && PENABLE && PWRITE;
    assign rd_en = PSEL && !PENABLE && !PWRITE;
    // Mapped word offsets; any other address answers with an error
    assign known = (PADDR == pmgr_pkg::ADDR_CTRL) || (PADDR == pmgr_pkg::ADDR_RCAUSE)
        || (PADDR == pmgr_pkg::ADDR_STAT) || (PADDR == pmgr_pkg::ADDR_CMD)
        || (PADDR == pmgr_pkg::ADDR_EVT);
    assign sleep_cmd = wr_en && PADDR == pmgr_pkg::ADDR_CMD && PWDATA[pmgr_pkg::CMD_SLEEP];
    assign watchdog_clear_instr_cmd = wr_en && PADDR == pmgr_pkg::ADDR_CMD && PWDATA[pmgr_pkg::CMD_WATCHDOG_CLEAR_INSTR];
    assign ev = (wr_en && PADDR == pmgr_pkg::ADDR_EVT) ? PWDATA[4:0] : 5'h00;
    // Only enabled sources with their flag set start a wake
    assign irq_wake = |(INT_FLAGS & INT_ENABLES); // [R12]
    assign halted = st_r.mode != pmgr_pkg::MODE_RUN && st_r.mode != pmgr_pkg::MODE_WAKE
        && st_r.mode != pmgr_pkg::MODE_OST;

    // Watchdog restarts on sleep, clear, clock loss with monitor, or expiry
    assign wdt_load = sleep_cmd || watchdog_clear_instr_cmd || wdt_done
        || (ev[pmgr_pkg::EV_CLKLOSS] && st_r.ctrl[pmgr_pkg::CTRL_FSCM]); // [R16]

    pmgr_counter #(.W(16)) u_wdt (
        .clk(CLK),
        .nrst(NRST),
        .load(wdt_load),
        .value(16'(WDT_CYCLES)),
        .run(st_r.ctrl[pmgr_pkg::CTRL_WDTEN]),
        .done(wdt_done)
    );
    pmgr_counter #(.W(16)) u_ready (
        .clk(CLK),
        .nrst(NRST),
        .load(ready_load),
        .value(16'(READY_CYCLES)),
        .run(st_r.mode == pmgr_pkg::MODE_WAKE),
        .done(ready_done)
    );
    pmgr_counter #(.W(16)) u_ost (
        .clk(CLK),
        .nrst(NRST),
        .load(ost_load),
        .value(16'(OST_CYCLES)),
        .run(st_r.mode == pmgr_pkg::MODE_OST),
        .done(ost_done)
    );

    always_comb begin
        logic wake;
        logic rst_evt;
        logic needs_ost;
        wake = 1'b0;
        rst_evt = 1'b0;
        needs_ost = 1'b0;
        st_nxt = st_r;
        st_nxt.resume = 1'b0;
        st_nxt.wdt_rst = 1'b0;
        ready_load = 1'b0;
        ost_load = 1'b0;
        rst_evt = |ev[3:0];
        // Register writes
        // Only software writes move the control bits; wake paths leave them alone
        if (wr_en && PADDR == pmgr_pkg::ADDR_CTRL) begin
            st_nxt.ctrl = PWDATA[7:0]; // [R10]
        end
        if (wr_en && PADDR == pmgr_pkg::ADDR_RCAUSE) begin
            // Software may only write the flags back to one
            st_nxt.prio = PWDATA[pmgr_pkg::RC_PRIO];
            st_nxt.mismatch_n = st_r.mismatch_n | PWDATA[pmgr_pkg::RC_MISMATCH]; // [R19]
            st_nxt.rstinstr_n = st_r.rstinstr_n | PWDATA[pmgr_pkg::RC_RSTINSTR]; // [R19]
            st_nxt.poweron_n = st_r.poweron_n | PWDATA[pmgr_pkg::RC_POWERON]; // [R22]
            st_nxt.brownout_n = (st_r.brownout_n | PWDATA[pmgr_pkg::RC_BROWNOUT])
                && st_r.ctrl[pmgr_pkg::CTRL_REGEN]; // [R22]
        end
        if (!st_r.ctrl[pmgr_pkg::CTRL_REGEN]) begin
            st_nxt.brownout_n = 1'b0; // [R22]
        end
        if (watchdog_clear_instr_cmd) begin
            st_nxt.timeout_n = 1'b1; // [R20]
            st_nxt.pwrdn_n = 1'b1; // [R21]
        end
        // Mode sequencing
        unique case (st_r.mode)
            pmgr_pkg::MODE_RUN: begin
                if (wdt_done) begin
                    st_nxt.wdt_rst = 1'b1; // [R15]
                    st_nxt.timeout_n = 1'b0; // [R20]
                    st_nxt.src = pmgr_pkg::SRC_RC;
                    st_nxt.pri_on = 1'b0;
                end else if (sleep_cmd) begin
                    if (!st_r.ctrl[pmgr_pkg::CTRL_IDLE]) begin
                        st_nxt.mode = pmgr_pkg::MODE_SLEEP; // [R23]
                        st_nxt.pri_on = 1'b0;
                        st_nxt.timeout_n = 1'b1; // [R20]
                        st_nxt.pwrdn_n = 1'b0; // [R21]
                    end else begin
                        unique case (st_r.ctrl[pmgr_pkg::CTRL_SEL +: 2])
                            pmgr_pkg::SEL_PRI: begin
                                st_nxt.mode = pmgr_pkg::MODE_PRIMARY_IDLE; // [R01]
                                st_nxt.src = pmgr_pkg::SRC_PRI; // [R02]
                                st_nxt.pri_on = 1'b1;
                            end
                            pmgr_pkg::SEL_SEC: begin
                                if (st_r.ctrl[pmgr_pkg::CTRL_SECEN]) begin
                                    st_nxt.mode = pmgr_pkg::MODE_SECONDARY_IDLE; // [R04]
                                    st_nxt.src = pmgr_pkg::SRC_SEC; // [R05]
                                    st_nxt.pri_on = 1'b0; // [R05]
                                end
                                // Otherwise sleep is ignored [R06]
                            end
                            default: begin
                                st_nxt.mode = pmgr_pkg::MODE_INT_IDLE; // [R08]
                                st_nxt.src = pmgr_pkg::SRC_RC; // [R08]
                                st_nxt.pri_on = 1'b0; // [R08]
                            end
                        endcase
                        if (st_nxt.mode != pmgr_pkg::MODE_RUN) begin
                            st_nxt.timeout_n = 1'b1; // [R20]
                            st_nxt.pwrdn_n = 1'b0; // [R21]
                        end
                    end
                end
            end
            pmgr_pkg::MODE_SLEEP, pmgr_pkg::MODE_PRIMARY_IDLE, pmgr_pkg::MODE_SECONDARY_IDLE,
            pmgr_pkg::MODE_INT_IDLE: begin
                // Only interrupt, reset or timeout end a halted mode
                wake = irq_wake || wdt_done || rst_evt; // [R11]
                if (wake) begin
                    st_nxt.wake_irq = irq_wake && !rst_evt;
                    st_nxt.branch = irq_wake && !rst_evt && GLOBAL_INT_EN; // [R13]
                    if (wdt_done) begin
                        st_nxt.timeout_n = 1'b0; // [R15] [R20]
                    end
                    if (rst_evt) begin
                        st_nxt.src = pmgr_pkg::SRC_RC; // [R17]
                        st_nxt.pri_on = 1'b0;
                        st_nxt.mode = pmgr_pkg::MODE_WAKE;
                        ready_load = 1'b1;
                    end else if (st_r.mode == pmgr_pkg::MODE_SLEEP) begin
                        needs_ost = st_r.ctrl[pmgr_pkg::CTRL_SEL +: 2] == pmgr_pkg::SEL_PRI
                            && !st_r.ctrl[pmgr_pkg::CTRL_EXTCLK]; // [R18]
                        unique case (st_r.ctrl[pmgr_pkg::CTRL_SEL +: 2])
                            pmgr_pkg::SEL_PRI: begin
                                st_nxt.src = pmgr_pkg::SRC_PRI;
                            end
                            pmgr_pkg::SEL_SEC: begin
                                st_nxt.src = pmgr_pkg::SRC_SEC;
                            end
                            default: begin
                                st_nxt.src = pmgr_pkg::SRC_RC;
                            end
                        endcase
                        st_nxt.pri_on = st_r.ctrl[pmgr_pkg::CTRL_SEL +: 2] == pmgr_pkg::SEL_PRI;
                        st_nxt.mode = needs_ost ? pmgr_pkg::MODE_OST : pmgr_pkg::MODE_WAKE;
                        ost_load = needs_ost;
                        ready_load = !needs_ost;
                    end else begin
                        // Idle exits keep the idle clock; no start-up timer [R03] [R07] [R09]
                        st_nxt.mode = pmgr_pkg::MODE_WAKE; // [R18]
                        ready_load = 1'b1; // [R14]
                    end
                end
            end
            pmgr_pkg::MODE_OST: begin
                if (ost_done) begin
                    st_nxt.mode = pmgr_pkg::MODE_WAKE;
                    ready_load = 1'b1; // [R14]
                end
            end
            pmgr_pkg::MODE_WAKE: begin
                if (ready_done || READY_CYCLES == 0) begin
                    st_nxt.mode = pmgr_pkg::MODE_RUN; // [R14]
                    st_nxt.resume = 1'b1;
                end
            end
            default: begin
                // Unused mode code recovers to run
                st_nxt.mode = pmgr_pkg::MODE_RUN;
            end
        endcase
        // Reset-source events clear their flags; clear wins over software write
        if (ev[pmgr_pkg::EV_MISMATCH]) begin
            st_nxt.mismatch_n = 1'b0; // [R19]
        end
        if (ev[pmgr_pkg::EV_RSTINSTR]) begin
            st_nxt.rstinstr_n = 1'b0; // [R19]
        end
        if (ev[pmgr_pkg::EV_POR]) begin
            st_nxt.poweron_n = 1'b0; // [R22]
            st_nxt.brownout_n = 1'b0; // [R22]
            st_nxt.timeout_n = 1'b1; // [R20]
            st_nxt.pwrdn_n = 1'b1; // [R21]
        end
        if (ev[pmgr_pkg::EV_BOR]) begin
            st_nxt.brownout_n = 1'b0; // [R22]
        end
        if (rst_evt && st_r.mode == pmgr_pkg::MODE_RUN) begin
            st_nxt.src = pmgr_pkg::SRC_RC;
            st_nxt.pri_on = 1'b0;
        end
        // Read data captured in the setup phase
        st_nxt.rdata = 32'h0000_0000;
        if (rd_en) begin
            if (PADDR == pmgr_pkg::ADDR_CTRL) begin
                st_nxt.rdata = {24'h000000, st_r.ctrl};
            end else if (PADDR == pmgr_pkg::ADDR_RCAUSE) begin
                st_nxt.rdata = {
                    24'h000000,
                    st_r.prio,
                    1'b0,
                    st_r.mismatch_n,
                    st_r.rstinstr_n,
                    st_r.timeout_n,
                    st_r.pwrdn_n,
                    st_r.poweron_n,
                    st_r.brownout_n
                };
            end else if (PADDR == pmgr_pkg::ADDR_STAT) begin
                st_nxt.rdata = {
                    24'h000000,
                    st_r.branch,
                    st_r.wake_irq,
                    st_r.src,
                    1'b0,
                    st_r.mode
                };
            end
        end else begin
            st_nxt.rdata = st_r.rdata;
        end
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            st_r <= '{
                mode: pmgr_pkg::MODE_RUN,
                src: pmgr_pkg::SRC_PRI,
                ctrl: 8'h04,
                prio: 1'b0,
                mismatch_n: 1'b1,
                rstinstr_n: 1'b1,
                timeout_n: 1'b1,
                pwrdn_n: 1'b1,
                poweron_n: 1'b0,
                brownout_n: 1'b0,
                wake_irq: 1'b0,
                pri_on: 1'b1,
                resume: 1'b0,
                branch: 1'b0,
                wdt_rst: 1'b0,
                rdata: 32'h0000_0000
            };
        end else begin
            st_r <= st_nxt;
        end
    end

    // No wait states: every access ends in its first access cycle
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !known;
    assign PRDATA = st_r.rdata;
    // CPU halted in every idle and sleep mode; peripherals only in full sleep and the start-up timer wait [R02] [R23]
    assign CPU_CLK_EN = st_r.mode == pmgr_pkg::MODE_RUN;
    assign PERIPH_CLK_EN = st_r.mode != pmgr_pkg::MODE_SLEEP && st_r.mode != pmgr_pkg::MODE_OST;
    assign CLK_SOURCE = st_r.src;
    assign PRIMARY_OSC_ON = st_r.pri_on;
    assign SECONDARY_OSC_ON = st_r.ctrl[pmgr_pkg::CTRL_SECEN]; // [R07]
    // RC kept alive by watchdog or clock monitor [R09]
    assign INTERNAL_RC_ON = st_r.src == pmgr_pkg::SRC_RC || st_r.ctrl[pmgr_pkg::CTRL_WDTEN]
        || st_r.ctrl[pmgr_pkg::CTRL_FSCM];
    assign PRIMARY_CLOCK_RUNNING_FLAG = st_r.src == pmgr_pkg::SRC_PRI && st_r.pri_on
        && st_r.mode != pmgr_pkg::MODE_SLEEP && st_r.mode != pmgr_pkg::MODE_OST; // [R02] [R03]
    assign SECONDARY_OSC_CLOCKING_FLAG = st_r.src == pmgr_pkg::SRC_SEC
        && st_r.mode != pmgr_pkg::MODE_SLEEP; // [R05]
    assign CPU_RESUME = st_r.resume;
    assign BRANCH_TO_VECTOR = st_r.resume && st_r.branch; // [R13]
    assign WATCHDOG_RESET = st_r.wdt_rst;
endmodule
`default_nettype wire

/* sim/pmgr_properties.sv */
// Checker of wake timing, watchdog and clock-status outputs of the sequencer
`default_nettype none
module pmgr_properties #(
    parameter int READY_CYCLES = 4
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // APB request side
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    // Core and clock status
    input wire logic CPU_CLK_EN,
    input wire logic PERIPH_CLK_EN,
    input wire logic [1:0] CLK_SOURCE,
    input wire logic PRIMARY_OSC_ON,
    input wire logic PRIMARY_CLOCK_RUNNING_FLAG,
    input wire logic SECONDARY_OSC_CLOCKING_FLAG,
    input wire logic CPU_RESUME,
    input wire logic BRANCH_TO_VECTOR,
    input wire logic WATCHDOG_RESET
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!NRST);
    // Cycles the CPU has been held, saturating
    logic [15:0] halt_cnt_r;
    always_ff @(posedge CLK) begin
        if (!NRST || CPU_CLK_EN) begin
            halt_cnt_r <= 16'h0000;
        end else if (halt_cnt_r != 16'hFFFF) begin
            halt_cnt_r <= halt_cnt_r + 16'h0001;
        end
    end
    sequence s_reset_evt;
        PSEL && PENABLE && PWRITE && PADDR == pmgr_pkg::ADDR_EVT && PWDATA[3:0] != 4'h0;
    endsequence
    sequence s_on_rc;
        CLK_SOURCE == pmgr_pkg::SRC_RC;
    endsequence
    property p_resume_pulse; CPU_RESUME |=> !CPU_RESUME; endproperty
    property p_resume_delay; CPU_RESUME |-> halt_cnt_r >= READY_CYCLES; endproperty
    property p_branch; BRANCH_TO_VECTOR |-> CPU_RESUME; endproperty
    property p_wdt_run; WATCHDOG_RESET |-> $past(CPU_CLK_EN); endproperty
    property p_wdt_rc; WATCHDOG_RESET |-> ##[0:2] s_on_rc; endproperty
    property p_flags; !(PRIMARY_CLOCK_RUNNING_FLAG && SECONDARY_OSC_CLOCKING_FLAG); endproperty
    property p_pri_flag; PRIMARY_CLOCK_RUNNING_FLAG |-> PRIMARY_OSC_ON; endproperty
    property p_run_periph; CPU_CLK_EN |-> PERIPH_CLK_EN; endproperty
    property p_reset_rc; s_reset_evt |-> ##[1:40] s_on_rc; endproperty
    a_resume_pulse: assert property (p_resume_pulse) else $error("resume wider than one cycle");
    a_resume_delay: assert property (p_resume_delay) else $error("resume before ready delay");
    a_branch: assert property (p_branch) else $error("branch without resume");
    a_wdt_run: assert property (p_wdt_run) else $error("watchdog reset while halted");
    a_wdt_rc: assert property (p_wdt_rc) else $error("no internal RC after watchdog reset");
    a_flags: assert property (p_flags) else $error("both clock status flags set");
    a_pri_flag: assert property (p_pri_flag) else $error("primary flag with primary off");
    a_run_periph: assert property (p_run_periph) else $error("peripherals stopped in run");
    a_reset_rc: assert property (p_reset_rc) else $error("reset event left RC unused");
endmodule
bind pmgr_top pmgr_properties #(.READY_CYCLES(READY_CYCLES)) u_pmgr_properties (.*);
`default_nettype wire

/* sim/tb.sv */
// Self-checking bench for idle entry, wake-up, watchdog and reset-cause flags
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RDY = 4;
    localparam int WDT = 50;
    localparam logic [11:0] A_CTRL = pmgr_pkg::ADDR_CTRL;
    localparam logic [11:0] A_RC = pmgr_pkg::ADDR_RCAUSE;
    localparam logic [11:0] A_CMD = pmgr_pkg::ADDR_CMD;
    logic clk, nrst, psel, penable, pwrite, pready, pslverr, gie, err, br;
    logic cpu_en, per_en, p_osc, s_osc, rc_on, p_flag, s_flag, resume, branch, wdt_rst;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, e, ctrl;
    logic [7:0] iflags, ienab;
    logic [1:0] src, sel;
    int mismatches, total_checks, cycles, seed, n, wdt_count, k;
    logic [1:0] sel_tab [4] = '{2'h2, 2'h1, 2'h0, 2'h3};
    logic [7:0] ev_mask [4] = '{8'h03, 8'h01, 8'h20, 8'h10};
    pmgr_top #(.READY_CYCLES(RDY), .OST_CYCLES(8), .WDT_CYCLES(WDT)) u_pmgr_top (
        .CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .INT_FLAGS(iflags), .INT_ENABLES(ienab), .GLOBAL_INT_EN(gie), .CPU_CLK_EN(cpu_en),
        .PERIPH_CLK_EN(per_en), .CLK_SOURCE(src), .PRIMARY_OSC_ON(p_osc),
        .SECONDARY_OSC_ON(s_osc), .INTERNAL_RC_ON(rc_on), .PRIMARY_CLOCK_RUNNING_FLAG(p_flag),
        .SECONDARY_OSC_CLOCKING_FLAG(s_flag), .CPU_RESUME(resume),
        .BRANCH_TO_VECTOR(branch), .WATCHDOG_RESET(wdt_rst));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic end_sim;
        $display("checks=%0d mismatches=%0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    always @(negedge clk) begin
        cycles++;
        if (wdt_rst === 1'b1) wdt_count++;
        if (cycles == 20000) begin
            mismatches++;
            end_sim();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One APB transfer and one idle cycle; entered and left just after a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int w;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        w = 0;
        do begin
            @(posedge clk);
            w++;
        end while (pready !== 1'b1 && w < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
        if (w >= 20) chk(32'h0, 32'h1);
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic wait_resume(input int lim);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (resume !== 1'b1 && n < lim);
        br = branch;
        chk({31'h0, resume}, 32'h1);
        chk({31'h0, n > RDY}, 32'h1);
        @(posedge clk);
    endtask
    function automatic logic [1:0] exp_src(input logic [1:0] s);
        return (s == 2'h2) ? 2'h0 : (s == 2'h1) ? 2'h1 : 2'h2;
    endfunction
    initial begin
        seed = 32'he4b74021;
        {nrst, psel, penable, pwrite, gie} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        {iflags, ienab} = 16'h0000;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rdchk(A_CTRL, 32'h04);
        rdchk(A_RC, 32'h3C);
        rdchk(12'h014, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("reset values done");
        for (int i = 0; i < 4; i++) begin
            sel = sel_tab[i];
            ctrl = 32'h9 | {29'h0, sel, 1'b0};
            e = $random(seed);
            apb(1'b1, A_CTRL, ctrl);
            apb(1'b1, A_CMD, 32'h1);
            ienab <= e[7:0] | 8'h01;
            iflags <= ~(e[7:0] | 8'h01);
            gie <= e[16];
            repeat (2) @(posedge clk);
            @(negedge clk);
            chk({cpu_en, per_en, src}, {2'b01, exp_src(sel)});
            chk({p_flag, s_flag, p_osc, s_osc},
                {(sel == 2'h2) ? 3'h5 : (sel == 2'h1) ? 3'h2 : 3'h0, 1'b1});
            repeat (10) @(posedge clk);
            chk({31'h0, cpu_en}, 32'h0);
            iflags <= iflags | 8'h01;
            wait_resume(100);
            chk({br, src}, {gie, exp_src(sel)});
            iflags <= 8'h00;
            rdchk(A_CTRL, ctrl);
            rdchk(A_RC, 32'h38);
        end
        $display("idle modes done");
        apb(1'b1, A_CTRL, 32'h3);
        apb(1'b1, A_CMD, 32'h2);
        apb(1'b1, A_CMD, 32'h1);
        repeat (3) @(posedge clk);
        chk({31'h0, cpu_en}, 32'h1);
        rdchk(A_RC, 32'h3C);
        apb(1'b1, A_CTRL, 32'h14);
        k = wdt_count;
        apb(1'b1, A_CMD, 32'h1);
        @(negedge clk);
        chk({cpu_en, per_en, rc_on}, 3'b001);
        @(posedge clk);
        wait_resume(200);
        chk(wdt_count, k);
        rdchk(A_RC, 32'h30);
        repeat (6) begin
            apb(1'b1, A_CMD, 32'h2);
            repeat (20) @(posedge clk);
        end
        chk(wdt_count, k);
        n = 0;
        while (wdt_count == k && n < WDT + 20) begin
            @(posedge clk);
            n++;
        end
        chk(wdt_count, k + 1);
        @(negedge clk);
        chk(src, 2'h2);
        @(posedge clk);
        rdchk(A_RC, 32'h34);
        apb(1'b1, A_CTRL, 32'h04);
        apb(1'b1, A_CMD, 32'h2);
        rdchk(A_RC, 32'h3C);
        $display("watchdog done");
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, A_CTRL, 32'h84);
            apb(1'b1, A_RC, 32'h33);
            apb(1'b1, pmgr_pkg::ADDR_EVT, 32'h1 << i);
            rdchk(A_RC, {24'h0, 8'h3F & ~ev_mask[i]});
        end
        apb(1'b1, A_CTRL, 32'h04);
        apb(1'b1, A_RC, 32'h01);
        rdchk(A_RC, 32'h2E);
        apb(1'b1, A_CTRL, 32'h05);
        apb(1'b1, A_CMD, 32'h1);
        repeat (3) @(posedge clk);
        apb(1'b1, pmgr_pkg::ADDR_EVT, 32'h8);
        wait_resume(200);
        chk(src, 2'h2);
        $display("reset flags done");
        // External clock: wake from sleep must skip the start-up timer
        apb(1'b1, A_CTRL, 32'h44);
        apb(1'b1, A_CMD, 32'h1);
        iflags <= 8'h01;
        wait_resume(RDY + 3);
        chk(src, 2'h0);
        $display("external clock done");
        end_sim();
    end
endmodule
`default_nettype wire
